/* File: pkg/host_port_pkg.sv */
package host_port_pkg;

	// link selection levels on the select pin
	localparam logic       SEL_UART       = 1'b0;
	localparam logic       SEL_SYNC       = 1'b1;

	// core clock and link rate limits
	localparam int         CLK_HZ         = 250_000_000;
	localparam int         UART_MAX_BPS   = 38_400;
	localparam int         SYNC_MAX_BPS   = 1_000_000;
	// cycles per bit at the fastest legal rate; these shortest times round down
	localparam int         UART_BIT_CYC   = CLK_HZ / UART_MAX_BPS;
	localparam int         SYNC_BIT_CYC   = CLK_HZ / SYNC_MAX_BPS;
	localparam int         SYNC_HALF_CYC  = SYNC_BIT_CYC / 2;

	// default width of the alert pulse in core cycles
	localparam int         ALERT_CYC_DEF  = 64;
	localparam int         CNT_W          = 16;

	// uart framing: start, 8 data, stop
	localparam int         DATA_W         = 8;
	localparam int         FRAME_BITS     = 10;
	localparam logic [3:0] BIT_LAST       = 4'h9;
	localparam logic [3:0] BIT_ZERO       = 4'h0;
	localparam logic [3:0] SYNC_LAST      = 4'h7;

	// idle level of an open-drain line with pull-up
	localparam logic       LINE_IDLE      = 1'b1;

	typedef enum logic [1:0] {
		TX_IDLE,
		TX_SHIFT,
		TX_ALERT
	} tx_state_t;

endpackage : host_port_pkg

/* File: pkg/host_port_if.sv */
`timescale 1ns/1ns
// pin-level link between the tag front end and the host
interface host_port_if;
	logic sel;          // select pin, driven by host: 0 uart, 1 sync
	logic rx;           // receive pin / serial clock, driven by host
	logic test;         // test control, host keeps low
	logic data_dev_o;   // device open-drain data output (drives low only)
	logic data_dev_oe;
	logic data_host_o;  // host data output in sync mode
	logic data_host_oe;
	logic alert_o;      // device alert output (drives low only)
	logic alert_oe;
	logic data_line;    // resolved data line with pull-up
	logic alert_line;   // resolved alert line with pull-up

	// wired-and with pull-up on both open-drain lines
	assign data_line  = ~((data_dev_oe & ~data_dev_o) | (data_host_oe & ~data_host_o));
	assign alert_line = ~(alert_oe & ~alert_o);

	modport dev (
		input  sel,
		input  rx,
		input  test,
		input  data_line,
		output data_dev_o,
		output data_dev_oe,
		output alert_o,
		output alert_oe
	);

	modport host (
		output sel,
		output rx,
		output test,
		output data_host_o,
		output data_host_oe,
		input  data_line,
		input  alert_line
	);
endinterface : host_port_if

/* File: rtl/host_port_dev.sv */
`timescale 1ns/1ns
module host_port_dev #(
	parameter int ALERT_CYC = host_port_pkg::ALERT_CYC_DEF
) (
	input  wire logic                             clock_i,
	input  wire logic                             rst_b_i,
	host_port_if.dev                              pins,
	// core side: byte to send to the host
	input  wire logic                             tx_valid_i,
	input  wire logic [host_port_pkg::DATA_W-1:0] tx_data_i,
	output logic                                  tx_ready_o,
	// core side: byte received from the host
	output logic                                  rx_valid_o,
	output logic      [host_port_pkg::DATA_W-1:0] rx_data_o,
	// core side: tunnel command arrived from the reader
	input  wire logic                             tunnel_cmd_i,
	output logic                                  sync_mode_o,
	output logic                                  test_mode_o
);
	import host_port_pkg::*;

	typedef struct packed {
		logic [1:0]        sel_s;
		logic [1:0]        rx_s;
		logic [1:0]        dl_s;
		logic [1:0]        test_s;
		logic              rx_prev;
		logic              sel_prev;
		tx_state_t         tx_st;
		logic [CNT_W-1:0]  tx_cnt;
		logic [3:0]        tx_bit;
		logic [FRAME_BITS-1:0] tx_sh;
		logic              rx_busy;
		logic [CNT_W-1:0]  rx_cnt;
		logic [3:0]        rx_bit;
		logic [DATA_W-1:0] rx_sh;
		logic              rx_valid;
		logic [DATA_W-1:0] rx_data;
		logic              alert_pend;
		logic [CNT_W-1:0]  alert_cnt;
		logic              drive_low;
	} dev_state_t;

	dev_state_t st_r;
	dev_state_t st_nxt;

	logic sel_q;
	logic rx_q;
	logic dl_q;
	logic sck_rise;
	logic sck_fall;

	////////////////////////////////////////////////////////////////////////
	// synchronised pins; only the second stage is read
	assign sel_q    = st_r.sel_s[1];
	assign rx_q     = st_r.rx_s[1];
	assign dl_q     = st_r.dl_s[1];
	assign sck_rise = sel_q == SEL_SYNC && rx_q && !st_r.rx_prev;
	assign sck_fall = sel_q == SEL_SYNC && !rx_q && st_r.rx_prev;

	////////////////////////////////////////////////////////////////////////
	// next-state logic for both link flavours
	always_comb begin
		st_nxt          = st_r;
		st_nxt.sel_s    = {st_r.sel_s[0], pins.sel};
		st_nxt.rx_s     = {st_r.rx_s[0], pins.rx};
		st_nxt.dl_s     = {st_r.dl_s[0], pins.data_line};
		st_nxt.test_s   = {st_r.test_s[0], pins.test};
		st_nxt.rx_prev  = rx_q;
		st_nxt.sel_prev = sel_q;
		st_nxt.rx_valid = 1'b0;

		// set wins over the send path consuming it
		if (tunnel_cmd_i) begin
			st_nxt.alert_pend = 1'b1;
			st_nxt.alert_cnt  = CNT_W'(ALERT_CYC);
		end else if (st_r.alert_cnt != '0) begin
			st_nxt.alert_cnt  = st_r.alert_cnt - 1'b1;
		end

		// transmit: uart frames, or sync bits shifted on falling clock
		unique case (st_r.tx_st)
			TX_IDLE: begin
				st_nxt.drive_low = 1'b0;
				if (tx_valid_i) begin
					st_nxt.tx_sh  = {1'b1, tx_data_i, 1'b0};
					st_nxt.tx_bit = BIT_ZERO;
					st_nxt.tx_cnt = CNT_W'(UART_BIT_CYC);
					st_nxt.tx_st  = TX_SHIFT;
					if (sel_q == SEL_SYNC) begin
						st_nxt.tx_sh = {2'b11, tx_data_i};   // msb first below
					end
				end else if (st_r.alert_pend && sel_q == SEL_UART) begin
					// uart hosts may watch the data line only
					st_nxt.alert_pend = tunnel_cmd_i;
					st_nxt.tx_cnt     = CNT_W'(ALERT_CYC);
					st_nxt.tx_st      = TX_ALERT;
				end else if (sel_q == SEL_SYNC) begin
					st_nxt.alert_pend = tunnel_cmd_i;
				end
			end
			TX_SHIFT: begin
				if (sel_q == SEL_UART) begin
					st_nxt.drive_low = ~st_r.tx_sh[st_r.tx_bit];
					if (st_r.tx_cnt == CNT_W'(1)) begin
						st_nxt.tx_cnt = CNT_W'(UART_BIT_CYC);
						st_nxt.tx_bit = st_r.tx_bit + 1'b1;
						if (st_r.tx_bit == BIT_LAST) begin
							st_nxt.tx_st = TX_IDLE;
						end
					end else begin
						st_nxt.tx_cnt = st_r.tx_cnt - 1'b1;
					end
				end else if (st_r.tx_bit == 4'(DATA_W)) begin
					// hold the last bit until the host's rise has sampled it
					if (sck_rise) begin
						st_nxt.tx_st = TX_IDLE;
					end
				end else if (sck_fall) begin
					st_nxt.drive_low = ~st_r.tx_sh[SYNC_LAST - st_r.tx_bit];
					st_nxt.tx_bit    = st_r.tx_bit + 1'b1;
				end
			end
			TX_ALERT: begin
				st_nxt.drive_low = 1'b1;
				st_nxt.tx_cnt    = st_r.tx_cnt - 1'b1;
				if (st_r.tx_cnt == CNT_W'(1)) begin
					st_nxt.tx_st = TX_IDLE;
				end
			end
		endcase

		// receive: uart samples mid-bit, sync samples on rising clock
		if (sel_q == SEL_UART) begin
			if (!st_r.rx_busy) begin
				if (!rx_q) begin
					st_nxt.rx_busy = 1'b1;
					st_nxt.rx_bit  = BIT_ZERO;
					st_nxt.rx_cnt  = CNT_W'(UART_BIT_CYC / 2);
				end
			end else if (st_r.rx_cnt == CNT_W'(1)) begin
				st_nxt.rx_cnt = CNT_W'(UART_BIT_CYC);
				st_nxt.rx_bit = st_r.rx_bit + 1'b1;
				if (st_r.rx_bit == BIT_ZERO && rx_q) begin
					st_nxt.rx_busy = 1'b0;                        // false start
				end else if (st_r.rx_bit == BIT_LAST) begin
					st_nxt.rx_busy  = 1'b0;
					st_nxt.rx_valid = rx_q;                        // stop bit good
					st_nxt.rx_data  = st_r.rx_sh;
				end else if (st_r.rx_bit != BIT_ZERO) begin
					st_nxt.rx_sh = {rx_q, st_r.rx_sh[DATA_W-1:1]};   // lsb first
				end
			end else begin
				st_nxt.rx_cnt = st_r.rx_cnt - 1'b1;
			end
		end else begin
			st_nxt.rx_busy = 1'b0;
			// device samples only while it is not sending a byte
			if (sck_rise && st_r.tx_st == TX_IDLE) begin
				st_nxt.rx_sh  = {st_r.rx_sh[DATA_W-2:0], dl_q};
				st_nxt.rx_bit = st_r.rx_bit + 1'b1;
				if (st_r.rx_bit == SYNC_LAST) begin
					st_nxt.rx_bit   = BIT_ZERO;
					st_nxt.rx_valid = 1'b1;
					st_nxt.rx_data  = {st_r.rx_sh[DATA_W-2:0], dl_q};
				end
			end
		end
		// settled select against its last value; the first stage stays unread
		if (sel_q != st_r.sel_prev) begin
			st_nxt.rx_bit = BIT_ZERO;   // a change of link drops a partial byte
		end
	end

	////////////////////////////////////////////////////////////////////////
	// state register
	always_ff @(posedge clock_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			st_r         <= '0;
			st_r.sel_s   <= 2'b00;
			st_r.rx_s    <= 2'b11;
			st_r.dl_s    <= 2'b11;
			st_r.rx_prev <= LINE_IDLE;
			st_r.tx_st   <= TX_IDLE;
		end else begin
			st_r <= st_nxt;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// open-drain pins: output is always low, enable asserts the pull-down
	assign pins.data_dev_o  = 1'b0;
	assign pins.data_dev_oe = st_r.drive_low;
	assign pins.alert_o     = 1'b0;
	assign pins.alert_oe    = st_r.alert_cnt != '0;
	assign tx_ready_o       = st_r.tx_st == TX_IDLE;
	assign rx_valid_o       = st_r.rx_valid;
	assign rx_data_o        = st_r.rx_data;
	assign sync_mode_o      = sel_q;
	assign test_mode_o      = st_r.test_s[1];

endmodule : host_port_dev

/* File: rtl/host_port_host.sv */
`timescale 1ns/1ns
// host end: drives select, clock or uart data, reads alert
module host_port_host (
	input  wire logic                             clock_i,
	input  wire logic                             rst_b_i,
	host_port_if.host                             pins,
	input  wire logic                             sync_sel_i,
	input  wire logic                             tx_valid_i,
	input  wire logic [host_port_pkg::DATA_W-1:0] tx_data_i,
	input  wire logic                             rd_i,
	output logic                                  tx_ready_o,
	output logic                                  rx_valid_o,
	output logic      [host_port_pkg::DATA_W-1:0] rx_data_o,
	output logic                                  alert_o
);
	import host_port_pkg::*;

	typedef struct packed {
		logic [1:0]        dl_s;
		logic [1:0]        al_s;
		logic              busy;
		logic              rd;
		logic [CNT_W-1:0]  cnt;
		logic [4:0]        bit_n;
		logic [FRAME_BITS-1:0] sh;
		logic              rx_line;
		logic              sck;
		logic              drive_low;
		logic              rx_valid;
		logic [DATA_W-1:0] rx_data;
		logic [DATA_W-1:0] rx_sh;
		logic              u_busy;
		logic [CNT_W-1:0]  u_cnt;
		logic [3:0]        u_bit;
	} host_state_t;

	host_state_t st_r;
	host_state_t st_nxt;

	////////////////////////////////////////////////////////////////////////
	// host is master: it paces bits at the device's top rates
	always_comb begin
		st_nxt          = st_r;
		st_nxt.dl_s     = {st_r.dl_s[0], pins.data_line};
		st_nxt.al_s     = {st_r.al_s[0], pins.alert_line};
		st_nxt.rx_valid = 1'b0;
		if (!st_r.busy) begin
			st_nxt.rx_line   = LINE_IDLE;
			st_nxt.sck       = LINE_IDLE;
			st_nxt.drive_low = 1'b0;
			if (tx_valid_i || (rd_i && sync_sel_i)) begin
				st_nxt.busy  = 1'b1;
				st_nxt.rd    = !tx_valid_i;
				st_nxt.bit_n = '0;
				st_nxt.cnt   = sync_sel_i ? CNT_W'(SYNC_HALF_CYC) : CNT_W'(UART_BIT_CYC);
				st_nxt.sh    = sync_sel_i ? {2'b11, tx_data_i} : {1'b1, tx_data_i, 1'b0};
			end
		end else if (st_r.cnt == CNT_W'(1)) begin
			st_nxt.bit_n = st_r.bit_n + 1'b1;
			if (!sync_sel_i) begin
				// uart: one frame bit per period
				st_nxt.cnt     = CNT_W'(UART_BIT_CYC);
				st_nxt.busy    = st_r.bit_n != 5'(FRAME_BITS);
				// the period after the stop bit only returns the pin to idle
				if (st_r.bit_n == 5'(FRAME_BITS)) begin
					st_nxt.rx_line = LINE_IDLE;
				end else begin
					st_nxt.rx_line = st_r.sh[st_r.bit_n[3:0]];
				end
			end else begin
				// sync: even half-periods low clock with data, odd rise
				st_nxt.cnt = CNT_W'(SYNC_HALF_CYC);
				st_nxt.sck = st_r.bit_n[0];
				if (!st_r.bit_n[0]) begin
					st_nxt.drive_low = !st_r.rd && !st_r.sh[SYNC_LAST - st_r.bit_n[3:1]];
				end else begin
					st_nxt.rx_sh = {st_r.rx_sh[DATA_W-2:0], st_r.dl_s[1]};
				end
				// the eighth rise ends the byte; a ninth edge would shift a stale bit
				if (st_r.bit_n == 5'(2 * DATA_W - 1)) begin
					st_nxt.busy     = 1'b0;
					st_nxt.rx_valid = st_r.rd;
					st_nxt.rx_data  = {st_r.rx_sh[DATA_W-2:0], st_r.dl_s[1]};
				end
			end
		end else begin
			st_nxt.cnt = st_r.cnt - 1'b1;
		end
		// uart receive from the device, sampled mid-bit after the synchroniser
		if (sync_sel_i) begin
			st_nxt.u_busy = 1'b0;
		end else if (!st_r.u_busy) begin
			if (!st_r.dl_s[1]) begin
				st_nxt.u_busy = 1'b1;
				st_nxt.u_bit  = BIT_ZERO;
				st_nxt.u_cnt  = CNT_W'(UART_BIT_CYC / 2);
			end
		end else if (st_r.u_cnt == CNT_W'(1)) begin
			st_nxt.u_cnt = CNT_W'(UART_BIT_CYC);
			st_nxt.u_bit = st_r.u_bit + 1'b1;
			if (st_r.u_bit == BIT_ZERO && st_r.dl_s[1]) begin
				st_nxt.u_busy = 1'b0;   // a short low such as the alert pulse is no start
			end else if (st_r.u_bit == BIT_LAST) begin
				st_nxt.u_busy   = 1'b0;
				st_nxt.rx_valid = st_r.dl_s[1];   // stop bit good
				st_nxt.rx_data  = st_r.rx_sh;
			end else if (st_r.u_bit != BIT_ZERO) begin
				st_nxt.rx_sh = {st_r.dl_s[1], st_r.rx_sh[DATA_W-1:1]};   // lsb first
			end
		end else begin
			st_nxt.u_cnt = st_r.u_cnt - 1'b1;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// state register
	always_ff @(posedge clock_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			st_r         <= '0;
			st_r.dl_s    <= 2'b11;
			st_r.al_s    <= 2'b11;
			st_r.rx_line <= LINE_IDLE;
			st_r.sck     <= LINE_IDLE;
		end else begin
			st_r <= st_nxt;
		end
	end

	assign pins.sel          = sync_sel_i;
	assign pins.rx           = sync_sel_i ? st_r.sck : st_r.rx_line;
	assign pins.test         = 1'b0;
	assign pins.data_host_o  = 1'b0;
	assign pins.data_host_oe = st_r.drive_low;
	assign tx_ready_o        = !st_r.busy;
	assign rx_valid_o        = st_r.rx_valid;
	assign rx_data_o         = st_r.rx_data;
	assign alert_o           = !st_r.al_s[1];

endmodule : host_port_host

/* File: bench/host_port_asserts.sv */
`timescale 1ns/1ns
// pin checks beside the link that joins the device end and the host end
module host_port_asserts
	import host_port_pkg::*;
#(
	parameter int ALERT_CYC = ALERT_CYC_DEF
) (
	input wire logic clock_i,
	input wire logic rst_b_i,
	input wire logic sel,
	input wire logic test,
	input wire logic data_dev_o,
	input wire logic data_dev_oe,
	input wire logic alert_o,
	input wire logic alert_oe
);
	logic [31:0] run_r;
	logic [15:0] hi_r;
	logic        prev_r;

	////////////////////////////////////////////////////////////////////////////////
	// run lengths of the data pull and the alert pull; widths are checked on release
	always_ff @(posedge clock_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			run_r  <= 32'h0;
			hi_r   <= 16'h0;
			prev_r <= 1'b0;
		end else begin
			prev_r <= data_dev_oe;
			run_r  <= (data_dev_oe != prev_r) ? 32'h1 : run_r + 32'h1;
			hi_r   <= alert_oe ? hi_r + 16'h1 : 16'h0;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	default clocking @(posedge clock_i); endclocking
	default disable iff (!rst_b_i);

	chk_dev_low_only: assert property (data_dev_oe |-> !data_dev_o)
		else $error("device drives data line high");
	chk_alert_low_only: assert property (alert_oe |-> !alert_o)
		else $error("device drives alert line high");
	chk_reset_idle: assert property ($rose(rst_b_i) |-> !data_dev_oe && !alert_oe)
		else $error("lines held after reset");
	chk_alert_width: assert property ($fell(alert_oe) |-> hi_r == 16'(ALERT_CYC))
		else $error("alert pulse width wrong");
	// a low stretch is whole bits, or the short alert pulse
	chk_uart_bit_time: assert property (!sel && prev_r && !data_dev_oe |->
		(run_r % UART_BIT_CYC == 0) || run_r == 32'(ALERT_CYC))
		else $error("uart low stretch not whole bits");
	chk_uart_stop_high: assert property (!sel && $fell(data_dev_oe) |=> !data_dev_oe [*8])
		else $error("line not released for stop bit");
	chk_uart_start_len: assert property (!sel && $rose(data_dev_oe) |-> data_dev_oe [*4])
		else $error("start bit too short");
	chk_test_low: assert property (!test)
		else $error("test input not low");
endmodule : host_port_asserts

/* File: bench/host_serial_port_select_irq_tb.sv */
`timescale 1ns/1ns
// device and host ends face each other; the bench drives both user sides
module host_serial_port_select_irq_tb;
	import host_port_pkg::*;
	localparam int ACYC = 4;
	logic       clock_i = 1'b0;
	logic       rst_b_i = 1'b0;
	logic       sel_sync = 1'b1;
	logic       d_txv = 1'b0, h_txv = 1'b0, h_rd = 1'b0, tun = 1'b0;
	logic [7:0] d_txd = 8'h00, h_txd = 8'h00, d_rxd, h_rxd, lo, ha;
	logic       d_rdy, d_rxv, smode, tmode, h_rdy, h_rxv, h_alert;
	int         n_fail = 0, check_count = 0, cyc = 0;

	host_port_if pins ();
	host_port_dev #(.ALERT_CYC(ACYC)) u_host_port_dev (.clock_i(clock_i), .rst_b_i(rst_b_i),
		.pins(pins.dev), .tx_valid_i(d_txv), .tx_data_i(d_txd), .tx_ready_o(d_rdy),
		.rx_valid_o(d_rxv), .rx_data_o(d_rxd), .tunnel_cmd_i(tun), .sync_mode_o(smode),
		.test_mode_o(tmode));
	host_port_host u_host_port_host (.clock_i(clock_i), .rst_b_i(rst_b_i), .pins(pins.host),
		.sync_sel_i(sel_sync), .tx_valid_i(h_txv), .tx_data_i(h_txd), .rd_i(h_rd),
		.tx_ready_o(h_rdy), .rx_valid_o(h_rxv), .rx_data_o(h_rxd), .alert_o(h_alert));
	host_port_asserts #(.ALERT_CYC(ACYC)) u_host_port_asserts (.clock_i(clock_i),
		.rst_b_i(rst_b_i), .sel(pins.sel), .test(pins.test), .data_dev_o(pins.data_dev_o),
		.data_dev_oe(pins.data_dev_oe), .alert_o(pins.alert_o), .alert_oe(pins.alert_oe));

	always #2 clock_i = ~clock_i;

	////////////////////////////////////////////////////////////////////////////////
	task automatic check(input logic [7:0] seen, input logic [7:0] exp);
		check_count++;
		if (seen !== exp) begin
			n_fail++;
			$display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask : check

	task automatic results();
		$display("checks %0d mismatches %0d", check_count, n_fail);
		if (n_fail == 0 && check_count > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask : results

	// one strobe held over one rising edge; send and read strobes find their end idle with ready high, the first tunnel strobe does not
	task automatic req(input int k, input logic [7:0] d);
		@(negedge clock_i);
		d_txd = d;
		h_txd = d;
		case (k)
			0: d_txv = 1'b1;
			1: h_txv = 1'b1;
			2: h_rd = 1'b1;
			default: tun = 1'b1;
		endcase
		@(negedge clock_i);
		{d_txv, h_txv, h_rd, tun} = 4'h0;
	endtask : req

	// the receive strobe stands one cycle, so every edge is looked at
	task automatic expect_rx(input bit at_host, input int lim, input logic [7:0] exp);
		int n;
		n = 0;
		do begin
			@(posedge clock_i);
			#1;
			n++;
		end while (!(at_host ? h_rxv === 1'b1 : d_rxv === 1'b1) && n < lim);
		if (n >= lim) n_fail++;
		check(at_host ? h_rxd : d_rxd, exp);
	endtask : expect_rx

	task automatic wait_check_line(input int cycles, input logic exp);
		repeat (cycles) @(posedge clock_i);
		#1;
		check({7'h0, pins.data_line}, {7'h0, exp});
	endtask : wait_check_line

	////////////////////////////////////////////////////////////////////////////////
	// a uart frame is long, so the run needs about 72400 cycles
	always @(posedge clock_i) begin
		cyc++;
		if (cyc == 90000) begin
			n_fail++;
			results();
		end
	end

	initial begin
		repeat (10) @(posedge clock_i);
		@(negedge clock_i);
		rst_b_i = 1'b1;
		wait_check_line(3, 1'b1);
		check({6'h0, smode, tmode}, 8'h02);
		$display("test reset done");
		req(1, 8'hA5);
		check({6'h0, h_rdy, d_rdy}, 8'h01);
		expect_rx(1'b0, 4000, 8'hA5);
		req(0, 8'h3D);
		check({6'h0, h_rdy, d_rdy}, 8'h02);
		req(2, 8'h00);
		expect_rx(1'b1, 4000, 8'h3D);
		$display("test sync done");
		req(3, 8'h00);
		lo = 8'h00;
		ha = 8'h00;
		// sampled on falling edges, where the pulse has settled
		repeat (20) begin
			lo = lo + {7'h0, pins.alert_line === 1'b0};
			ha = ha + {7'h0, h_alert === 1'b1};
			@(negedge clock_i);
		end
		check(lo, 8'(ACYC));
		check(ha, 8'(ACYC));
		$display("test alert done");
		sel_sync = 1'b0;
		repeat (6) @(posedge clock_i);
		#1;
		check({7'h0, smode}, 8'h00);
		req(1, 8'hC3);
		req(0, 8'hA5);
		wait_check_line(UART_BIT_CYC / 2, 1'b0);
		wait_check_line(UART_BIT_CYC, 1'b1);
		check({6'h0, h_rdy, d_rdy}, 8'h00);
		fork
			expect_rx(1'b1, 70000, 8'hA5);
			expect_rx(1'b0, 70000, 8'hC3);
		join
		check({7'h0, d_rdy}, 8'h01);
		$display("test uart done");
		// in uart mode the alert also pulls the data line for the pulse width
		req(3, 8'h00);
		wait_check_line(2, 1'b0);
		wait_check_line(ACYC + 1, 1'b1);
		$display("test uart alert done");
		results();
	end
endmodule : host_serial_port_select_irq_tb
